// file: qei_core.v
// Summary of operation
// RQ1: Position and velocity enable separately; velocity runs only with position enabled.
// RQ2: Swap bit exchanges the phase inputs before decoding.
// RQ3: Signal mode clear decodes quadrature; first-edge phase sets direction.
// RQ4: Signal mode set: input A is step clock, input B direction level.
// RQ5: Capture mode 0 counts A edges only; 1 counts both phases.
// RQ6: A leading B counts up; B leading A counts down.
// RQ7: Rise and fall on one phase without other-phase edge flags direction change.
// RQ8: Reset mode chooses index reset or maximum-position wrap.
// RQ9: Reset mode 0 clears the position on each index pulse.
// RQ10: In index mode, counting down from 0 goes to the maximum.
// RQ11: In index mode position is absolute to the index once seen.
// RQ12: Reset mode 1 keeps position in 0..max and ignores index.
// RQ13: Velocity counts edges with the same mode, capture and swap settings.
// RQ14: At period end speed takes the count, count clears, new period begins.
// RQ15: Timer counts down, reloads from load value at zero, raises an event.
// RQ16: Velocity edges pass through the predivider; value 0 divides by one.
// RQ17: Events exist for phase error, direction change, index and timer.
// RQ18: Each event has a mask, raw status, masked status and clear.
// RQ19: Software configures, then enables, then reads the position.
// RQ20: Phase and index inputs are synchronised and edge-detected first.
// RQ21: Both phases changing in one sample raises the phase error event; the code raises it only while enabled with signal mode clear.
`include "qei_map.vh"
module qei_core #(
  parameter DIV_W = 3
) (
  input  wire        i_mclk,
  input  wire        i_srst,
  input  wire        i_phase_a_in,
  input  wire        i_phase_b_in,
  input  wire        i_index_in,
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output wire [1:0]  o_bresp,
  output wire        o_bvalid,
  input  wire        i_bready,
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output wire [31:0] o_rdata,
  output wire [1:0]  o_rresp,
  output wire        o_rvalid,
  input  wire        i_rready,
  output wire        o_irq
);

  // ----------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------
  reg  [2:0] sync1_r;
  reg  [2:0] sync2_r;
  reg  [2:0] prev_r;

  always @(posedge i_mclk) begin
    if (i_srst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r  <= 3'h0;
    end else begin
      sync1_r <= {i_index_in, i_phase_b_in, i_phase_a_in}; // RQ20
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [31:0] ctl_r;
  reg  [31:0] pos_r;
  reg  [31:0] maxpos_r;
  reg  [31:0] load_r;
  reg  [31:0] time_r;
  reg  [31:0] count_r;
  reg  [31:0] speed_r;
  reg  [`QEI_INT_W-1:0] inten_r;
  reg  [`QEI_INT_W-1:0] ris_r;
  reg         dir_r;
  reg         err_r;
  reg         last_ph_r;
  reg         last_lvl_r;
  reg         last_vld_r;

  wire        en      = ctl_r[`QEI_CTL_ENABLE];
  wire        vel_en  = ctl_r[`QEI_CTL_VELEN] & en; // RQ1
  wire        swap    = ctl_r[`QEI_CTL_SWAP];
  wire        signal_mode_sel = ctl_r[`QEI_CTL_SIGNAL_MODE_SEL];
  wire        capture_mode_sel = ctl_r[`QEI_CTL_CAPTURE_MODE_SEL];
  wire        reset_mode_sel = ctl_r[`QEI_CTL_RESET_MODE_SEL];
  wire [DIV_W-1:0] vdiv = ctl_r[`QEI_CTL_DIV_HI:`QEI_CTL_DIV_LO];

  // ----------------------------------------
  // Phase decode
  // ----------------------------------------
  wire a_now  = swap ? sync2_r[1] : sync2_r[0]; // RQ2
  wire b_now  = swap ? sync2_r[0] : sync2_r[1]; // RQ2
  wire a_old  = swap ? prev_r[1]  : prev_r[0];
  wire b_old  = swap ? prev_r[0]  : prev_r[1];
  wire a_chg  = a_now ^ a_old;
  wire b_chg  = b_now ^ b_old;
  wire idx_ev = sync2_r[2] & ~prev_r[2];

  // Quadrature: A leads B when after the edge the phases differ on A edge
  wire q_dir_a = (a_now != b_now); // RQ6
  wire q_dir_b = (a_now == b_now); // RQ6
  wire phase_err = en & ~signal_mode_sel & a_chg & b_chg; // RQ21

  reg  step;
  reg  up;

  always @* begin
    step = 1'b0;
    up   = 1'b1;
    if (signal_mode_sel) begin
      step = a_chg & a_now;                       // RQ4
      up   = ~b_now;                              // RQ4
    end else if (!phase_err) begin
      if (a_chg) begin
        step = 1'b1;                              // RQ3 RQ5
        up   = q_dir_a;
      end else if (b_chg) begin
        step = capture_mode_sel;                           // RQ5
        up   = q_dir_b;                           // RQ6
      end
    end
  end

  // Direction reversal: two edges in a row on the same phase, or in signal mode a step whose direction level differs from the last
  wire any_chg  = (a_chg | b_chg) & ~phase_err & ~signal_mode_sel;
  wire cur_ph   = b_chg;
  wire rev_q    = any_chg & last_vld_r & (cur_ph == last_ph_r); // RQ7
  wire rev_c    = signal_mode_sel & step & last_vld_r & (up != last_lvl_r);
  wire dir_ev   = en & (rev_q | rev_c);
  wire cnt_step = en & step;

  // ----------------------------------------
  // Position integrator and direction state
  // ----------------------------------------
  reg  [31:0] pos_nxt;

  always @* begin
    pos_nxt = pos_r;
    if (cnt_step) begin
      if (up) begin
        pos_nxt = (pos_r >= maxpos_r) ? 32'h00000000 : pos_r + 32'h00000001; // RQ12
      end else begin
        pos_nxt = (pos_r == 32'h00000000) ? maxpos_r : pos_r - 32'h00000001; // RQ10
      end
    end
    if (en && !reset_mode_sel && idx_ev) begin
      pos_nxt = 32'h00000000; // RQ8 RQ9 RQ11
    end
  end

  // ----------------------------------------
  // Velocity capture
  // ----------------------------------------
  wire vel_edge;
  wire tmr_ev = vel_en & (time_r == 32'h00000000);

  qei_prediv #(
    .DIV_W (DIV_W)
  ) u_prediv (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_clr  (~vel_en),
    .i_edge (vel_en & cnt_step), // RQ13
    .i_div  (vdiv),              // RQ16
    .o_edge (vel_edge)
  );

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  reg         aw_ok_r;
  reg         w_ok_r;
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         rvalid_r;
  reg  [31:0] rdata_r;
  reg  [1:0]  rresp_r;

  assign o_awready = ~aw_ok_r & ~bvalid_r;
  assign o_wready  = ~w_ok_r & ~bvalid_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_arready = ~rvalid_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;

  wire do_wr = aw_ok_r & w_ok_r & ~bvalid_r;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `QEI_OFS_ISC);
    end
  endfunction

  wire wr_ctl  = do_wr && awaddr_r == `QEI_OFS_CTL;
  wire wr_pos  = do_wr && awaddr_r == `QEI_OFS_POS;
  wire wr_max  = do_wr && awaddr_r == `QEI_OFS_MAXPOS;
  wire wr_load = do_wr && awaddr_r == `QEI_OFS_LOAD;
  wire wr_ien  = do_wr && awaddr_r == `QEI_OFS_INTEN;
  wire wr_isc  = do_wr && awaddr_r == `QEI_OFS_ISC;
  wire [31:0] wmerged = merge(`QEI_RST_WORD, wdata_r, wstrb_r);

  always @(posedge i_mclk) begin
    if (i_srst) begin
      aw_ok_r  <= 1'b0;
      w_ok_r   <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= `QEI_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_ok_r  <= 1'b1;
        awaddr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_ok_r  <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      if (do_wr) begin
        aw_ok_r  <= 1'b0;
        w_ok_r   <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (mapped(awaddr_r) && (wr_ctl || wr_pos || wr_max || wr_load || wr_ien || wr_isc ||
                     awaddr_r == `QEI_OFS_STAT || awaddr_r == `QEI_OFS_TIME || awaddr_r == `QEI_OFS_COUNT ||
                     awaddr_r == `QEI_OFS_SPEED || awaddr_r == `QEI_OFS_RIS)) ?
                    `QEI_RESP_OKAY : `QEI_RESP_SLVERR;
      end else if (bvalid_r && i_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `QEI_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= mapped(i_araddr) ? `QEI_RESP_OKAY : `QEI_RESP_SLVERR;
      case (i_araddr)
        `QEI_OFS_CTL:    rdata_r <= ctl_r;
        `QEI_OFS_STAT:   rdata_r <= {30'h0, dir_r, err_r};
        `QEI_OFS_POS:    rdata_r <= pos_r;
        `QEI_OFS_MAXPOS: rdata_r <= maxpos_r;
        `QEI_OFS_LOAD:   rdata_r <= load_r;
        `QEI_OFS_TIME:   rdata_r <= time_r;
        `QEI_OFS_COUNT:  rdata_r <= count_r;
        `QEI_OFS_SPEED:  rdata_r <= speed_r;
        `QEI_OFS_INTEN:  rdata_r <= {28'h0, inten_r};
        `QEI_OFS_RIS:    rdata_r <= {28'h0, ris_r};        // RQ18
        `QEI_OFS_ISC:    rdata_r <= {28'h0, ris_r & inten_r}; // RQ18
        default:         rdata_r <= 32'h00000000;
      endcase
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Core state update
  // ----------------------------------------
  wire [`QEI_INT_W-1:0] ev;
  assign ev[`QEI_INT_INDEX] = en & idx_ev;   // RQ17
  assign ev[`QEI_INT_TIMER] = tmr_ev;        // RQ15 RQ17
  assign ev[`QEI_INT_DIR]   = dir_ev;        // RQ17
  assign ev[`QEI_INT_ERROR] = phase_err;     // RQ17 RQ21

  always @(posedge i_mclk) begin
    if (i_srst) begin
      ctl_r      <= `QEI_RST_WORD;
      pos_r      <= `QEI_RST_WORD;
      maxpos_r   <= `QEI_RST_WORD;
      load_r     <= `QEI_RST_WORD;
      time_r     <= `QEI_RST_WORD;
      count_r    <= `QEI_RST_WORD;
      speed_r    <= `QEI_RST_WORD;
      inten_r    <= {`QEI_INT_W{1'b0}};
      ris_r      <= {`QEI_INT_W{1'b0}};
      dir_r      <= 1'b0;
      err_r      <= 1'b0;
      last_ph_r  <= 1'b0;
      last_lvl_r <= 1'b0;
      last_vld_r <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_r <= merge(ctl_r, wdata_r, wstrb_r) & `QEI_CTL_WMASK;
      end
      if (wr_max) begin
        maxpos_r <= merge(maxpos_r, wdata_r, wstrb_r);
      end
      if (wr_load) begin
        load_r <= merge(load_r, wdata_r, wstrb_r);
      end
      if (wr_ien) begin
        inten_r <= wmerged[`QEI_INT_W-1:0];
      end
      pos_r <= wr_pos ? merge(pos_r, wdata_r, wstrb_r) : pos_nxt;
      // Set wins over write-one-to-clear
      ris_r <= (ris_r & ~(wr_isc ? wmerged[`QEI_INT_W-1:0] : {`QEI_INT_W{1'b0}})) | ev; // RQ18
      if (phase_err) begin
        err_r <= 1'b1;
      end else if (a_chg | b_chg) begin
        err_r <= 1'b0;
      end
      if (cnt_step) begin
        dir_r <= ~up;
      end
      if (!en) begin
        last_vld_r <= 1'b0;
      end else if (any_chg) begin
        last_ph_r  <= cur_ph;
        last_vld_r <= 1'b1;
      end else if (signal_mode_sel && step) begin
        last_lvl_r <= up;
        last_vld_r <= 1'b1;
      end
      if (!vel_en) begin
        time_r  <= load_r;
        count_r <= 32'h00000000;
      end else if (tmr_ev) begin
        time_r  <= load_r;                                 // RQ15
        speed_r <= count_r + {31'h0, vel_edge};            // RQ14
        count_r <= 32'h00000000;                           // RQ14
      end else begin
        time_r  <= time_r - 32'h00000001;
        count_r <= count_r + {31'h0, vel_edge};            // RQ13 RQ16
      end
    end
  end

  assign o_irq = |(ris_r & inten_r);

endmodule

// file: qei_core_asserts.sv
`include "qei_map.vh"
module qei_core_asserts (
  input logic        i_mclk,
  input logic        i_srst,
  input logic [7:0]  i_awaddr,
  input logic        i_awvalid,
  input logic        o_awready,
  input logic        i_wvalid,
  input logic        o_wready,
  input logic [1:0]  o_bresp,
  input logic        o_bvalid,
  input logic        i_bready,
  input logic [7:0]  i_araddr,
  input logic        i_arvalid,
  input logic        o_arready,
  input logic [31:0] o_rdata,
  input logic [1:0]  o_rresp,
  input logic        o_rvalid,
  input logic        i_rready,
  input logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  wire ar_bad = i_araddr > 8'h28 || i_araddr[1:0] != 2'h0;
  wire aw_bad = i_awaddr > 8'h28 || i_awaddr[1:0] != 2'h0;
  wire w_both = i_awvalid && o_awready && i_wvalid && o_wready;
  // --------
  // Bus answers
  // --------
  rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("no read answer");
  rd_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read answer dropped");
  rd_block_a: assert property (o_rvalid |-> !o_arready) else $error("read taken while busy");
  rd_err_a: assert property (i_arvalid && o_arready && ar_bad |=> o_rresp == `QEI_RESP_SLVERR && o_rdata == 32'h0)
    else $error("bad read not refused");
  rd_ok_a: assert property (i_arvalid && o_arready && !ar_bad |=> o_rresp == `QEI_RESP_OKAY)
    else $error("good read refused");
  wr_answer_a: assert property (w_both |=> !o_awready && !o_wready ##1 o_bvalid)
    else $error("no write answer");
  wr_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped");
  wr_done_a: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("write answer repeated");
  wr_err_a: assert property (w_both && aw_bad |=> ##1 o_bvalid && o_bresp == `QEI_RESP_SLVERR)
    else $error("bad write not refused");
  irq_reset_a: assert property (disable iff (1'b0) i_srst |=> !o_irq) else $error("irq set in reset");
endmodule

bind qei_core qei_core_asserts u_chk (.i_mclk, .i_srst, .i_awaddr, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
  .o_irq);

// file: qei_core_bench.sv
`include "qei_map.vh"
module qei_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk = 0;
  logic        i_srst = 1;
  logic [7:0]  i_awaddr = 0, i_araddr = 0;
  logic        i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [31:0] i_wdata = 0, d;
  logic [3:0]  i_wstrb = 0;
  wire         i_phase_a_in, i_phase_b_in, i_index_in, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  wire  [1:0]  o_bresp, o_rresp;
  wire  [31:0] o_rdata;
  integer      seed = 32'h5DCD193A;
  int          failures = 0, n_tests = 0, pos = 0, mx = 0, edg = 0;
  int          cf[3] = '{'h19, 'h11, 'h1B};
  int          cd[7] = '{2, 0, 2, 0, 1, 3, 1};
  bit          en = 0, cap = 0, swp = 0;
  always #50 i_mclk = ~i_mclk;
  qei_core DUT (.i_mclk, .i_srst, .i_phase_a_in, .i_phase_b_in, .i_index_in, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq);
  qei_enc_model enc (.i_mclk, .o_pha(i_phase_a_in), .o_phb(i_phase_b_in), .o_idx(i_index_in));
  // --------
  // Bus master and reference model
  // --------
  function automatic int rnd(int n);
    return {1'b0, $random(seed)} % n;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = 0, input logic [3:0] s = 4'hF);
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= v;
    i_wstrb <= s;
    i_awvalid <= 1;
    i_wvalid <= 1;
    fork
      begin
        do @(posedge i_mclk); while (!o_awready);
        i_awvalid <= 0;
      end
      begin
        do @(posedge i_mclk); while (!o_wready);
        i_wvalid <= 0;
      end
    join
    repeat (rnd(3)) @(posedge i_mclk);
    i_bready <= 1;
    do @(posedge i_mclk); while (!o_bvalid);
    i_bready <= 0;
    chk(o_bresp, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1, input logic [1:0] r = 0);
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1;
    do @(posedge i_mclk); while (!o_arready);
    i_arvalid <= 0;
    repeat (rnd(3)) @(posedge i_mclk);
    i_rready <= 1;
    do @(posedge i_mclk); while (!o_rvalid);
    i_rready <= 0;
    d = o_rdata;
    chk(d & m, e);
    chk(o_rresp, r);
  endtask
  task automatic mv(input bit up, input int n);
    bit ae;
    repeat (n) begin
      ae = up ? enc.st % 2 == 0 : enc.st % 2 == 1;
      if (en && (cap || (ae ^ swp))) begin
        pos = (up ^ swp) ? (pos >= mx ? 0 : pos + 1) : (pos == 0 ? mx : pos - 1);
        edg++;
      end
      enc.step(up, 1 + rnd(5));
    end
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic cfg(input int c);
    wr(`QEI_OFS_CTL, c);
    {cap, swp, en} = {c[3], c[1], c[0]};
    repeat (4) @(posedge i_mclk);
    wr(`QEI_OFS_POS, 0);
    pos = 0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // --------
  // Scenarios
  // --------
  initial begin
    repeat (2) @(posedge i_mclk);
    i_srst <= 0;
    for (int a = 0; a <= 'h2C; a += 4) rd(a[7:0], `QEI_RST_WORD, '1, a > 'h28 ? `QEI_RESP_SLVERR : `QEI_RESP_OKAY);
    rd(8'h06, 0, '1, `QEI_RESP_SLVERR);
    wr(8'h2C, 1, `QEI_RESP_SLVERR);
    wr(`QEI_OFS_TIME, '1);
    rd(`QEI_OFS_TIME, 0);
    wr(`QEI_OFS_MAXPOS, '1, 0, 4'h1);
    rd(`QEI_OFS_MAXPOS, 32'hFF);
    wr(`QEI_OFS_CTL, '1);
    rd(`QEI_OFS_CTL, `QEI_CTL_WMASK);
    wr(`QEI_OFS_MAXPOS, 7);
    mx = 7;
    foreach (cf[i]) begin
      cfg(cf[i]);
      repeat (40) mv(rnd(2), 1);
      rd(`QEI_OFS_POS, pos);
    end
    cfg('h19);
    mv(1, 1);
    wr(`QEI_OFS_ISC, 'hF);
    mv(1, 2);
    rd(`QEI_OFS_RIS, 0, 4);
    mv(0, 1);
    rd(`QEI_OFS_RIS, 4, 4);
    rd(`QEI_OFS_STAT, 2, 2);
    enc.put(~enc.o_pha, ~enc.o_phb, 4);
    rd(`QEI_OFS_STAT, 1, 1);
    rd(`QEI_OFS_RIS, 8, 8);
    wr(`QEI_OFS_INTEN, 1);
    repeat (2) @(posedge i_mclk);
    chk(o_irq, 0);
    rd(`QEI_OFS_ISC, 0, 8);
    wr(`QEI_OFS_INTEN, 8);
    repeat (2) @(posedge i_mclk);
    chk(o_irq, 1);
    rd(`QEI_OFS_ISC, 8, 8);
    wr(`QEI_OFS_ISC, 8);
    repeat (2) @(posedge i_mclk);
    chk(o_irq, 0);
    rd(`QEI_OFS_RIS, 0, 8);
    enc.put(0, 0, 3);
    cfg('h15);
    foreach (cd[i]) enc.put(cd[i][1], cd[i][0], 3);
    rd(`QEI_OFS_POS, 1);
    enc.put(0, 0, 3);
    wr(`QEI_OFS_MAXPOS, 15);
    mx = 15;
    cfg('h09);
    mv(1, 5);
    enc.pulse(3);
    pos = 0;
    rd(`QEI_OFS_POS, 0);
    rd(`QEI_OFS_RIS, 1, 1);
    mv(0, 1);
    rd(`QEI_OFS_POS, 15);
    cfg('h19);
    mv(1, 3);
    enc.pulse(3);
    rd(`QEI_OFS_POS, pos);
    cfg('h28);
    mv(1, 8);
    rd(`QEI_OFS_COUNT, 0);
    rd(`QEI_OFS_POS, 0);
    wr(`QEI_OFS_LOAD, 600);
    for (int v = 0; v < 3; v++) begin
      cfg('h09);
      edg = 0;
      wr(`QEI_OFS_CTL, 'h29 | v << 6);
      repeat (16) mv(rnd(2), 1);
      rd(`QEI_OFS_COUNT, edg >> v);
      wr(`QEI_OFS_ISC, 'hF);
      d = 0;
      for (int k = 0; k < 300 && d[1] !== 1'b1; k++) rd(`QEI_OFS_RIS, 0, 0);
      rd(`QEI_OFS_RIS, 2, 2);
      rd(`QEI_OFS_SPEED, edg >> v);
      rd(`QEI_OFS_COUNT, 0);
      rd(`QEI_OFS_POS, pos);
    end
    end_sim();
  end
  initial begin
    repeat (30000) @(posedge i_mclk);
    failures++;
    end_sim();
  end
endmodule

// file: qei_enc_model.sv
module qei_enc_model (
  input  wire logic i_mclk,
  output logic      o_pha,
  output logic      o_phb,
  output logic      o_idx
);
  timeunit 1ns;
  timeprecision 1ns;
  int st = 0;
  initial begin
    o_pha = 0;
    o_phb = 0;
    o_idx = 0;
  end
  // --------
  // Wheel motion, phases stand still between steps
  // --------
  task automatic step(input bit up, input int gap);
    int n;
    n = up ? (st + 1) % 4 : (st + 3) % 4;
    put(n == 1 || n == 2, n >= 2, gap);
  endtask
  task automatic put(input bit a, input bit b, input int gap);
    @(posedge i_mclk);
    o_pha <= a;
    o_phb <= b;
    st = a ? (b ? 2 : 1) : (b ? 3 : 0);
    repeat (gap) @(posedge i_mclk);
  endtask
  task automatic pulse(input int w);
    @(posedge i_mclk);
    o_idx <= 1;
    repeat (w) @(posedge i_mclk);
    o_idx <= 0;
    repeat (w) @(posedge i_mclk);
  endtask
endmodule

// file: qei_map.vh
`ifndef QEI_MAP_VH
`define QEI_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define QEI_OFS_CTL      8'h00
`define QEI_OFS_STAT     8'h04
`define QEI_OFS_POS      8'h08
`define QEI_OFS_MAXPOS   8'h0C
`define QEI_OFS_LOAD     8'h10
`define QEI_OFS_TIME     8'h14
`define QEI_OFS_COUNT    8'h18
`define QEI_OFS_SPEED    8'h1C
`define QEI_OFS_INTEN    8'h20
`define QEI_OFS_RIS      8'h24
`define QEI_OFS_ISC      8'h28
// ----------------------------------------
// Control fields
// ----------------------------------------
`define QEI_CTL_ENABLE   0
`define QEI_CTL_SWAP     1
`define QEI_CTL_SIGNAL_MODE_SEL  2
`define QEI_CTL_CAPTURE_MODE_SEL  3
`define QEI_CTL_RESET_MODE_SEL  4
`define QEI_CTL_VELEN    5
`define QEI_CTL_DIV_LO   6
`define QEI_CTL_DIV_HI   8
`define QEI_CTL_WMASK    32'h000001FF
// ----------------------------------------
// Status and interrupt fields
// ----------------------------------------
`define QEI_STAT_ERROR   0
`define QEI_STAT_DIR     1
`define QEI_INT_INDEX    0
`define QEI_INT_TIMER    1
`define QEI_INT_DIR      2
`define QEI_INT_ERROR    3
`define QEI_INT_W        4
// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define QEI_RST_WORD     32'h00000000
`define QEI_RESP_OKAY    2'h0
`define QEI_RESP_SLVERR  2'h2
`endif

// file: qei_prediv.v
// ----------------------------------------
// Velocity predivider: passes one of 2^div edges
// ----------------------------------------
module qei_prediv #(
  parameter DIV_W = 3
) (
  input  wire             i_mclk,
  input  wire             i_srst,
  input  wire             i_clr,
  input  wire             i_edge,
  input  wire [DIV_W-1:0] i_div,
  output wire             o_edge
);

  reg  [7:0] cnt_r;
  wire [7:0] lim;

  assign lim    = (8'h01 << i_div) - 8'h01;
  assign o_edge = i_edge && (cnt_r == lim);

  always @(posedge i_mclk) begin
    if (i_srst || i_clr) begin
      cnt_r <= 8'h00;
    end else if (i_edge) begin
      if (cnt_r == lim) begin
        cnt_r <= 8'h00;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

endmodule
